// ### rtl/irqfe_flag_enable.sv
// Behaviour
// R1: bit 1 of flags group 4 holds the serial-port error request flag.
// R2: the serial error flag reads one once its request has occurred.
// R3: the serial error flag reads zero while no request has occurred.
// R4: flags group 4 bits 15 to 2 read zero and ignore writes.
// R5: flags group 4 bit 0 reads zero.
// R6: serial error flag is software read/write and resets to zero.
// R7: enables group 0 has thirteen read/write enables; bits 15,14,4 read zero.
// R8: an enable of one permits its source; zero blocks it.
// R9: forward request only when flag and enable are both one; flag sets regardless.
//
// The address map and the Avalon-MM slave port were decided locally.
`include "irqfe_cfg.svh"
`default_nettype none
module irqfe_flag_enable #(
  parameter int NSRC = `IRQFE_NSRC
) (
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  // avalon-mm slave
  input  wire logic [`IRQFE_ADDR_W-1:0]  avAddress,
  input  wire logic                      avRead,
  input  wire logic                      avWrite,
  input  wire logic [31:0]               avWriteData,
  input  wire logic [3:0]                avByteEnable,
  output var  logic [31:0]               avReadData,
  output logic                           avWaitRequest,
  // serial error event and other flags
  input  wire logic                      serialErrorEvent,
  input  wire logic [15:0]               srcFlags,
  // to and from priority logic
  output var  logic [15:0]               irqEnables,
  output var  logic                      serialErrorFlag,
  output var  logic [15:0]               irqForward,
  output var  logic                      serialErrorForward,
  input  wire logic                      serialErrorEnable,
  // interrupt
  output logic                           irqOut
);
  import irqfe_pkg::*;

  irqfe_word_t flags4_q;
  irqfe_word_t enables0_q;
  logic [`IRQFE_STAT_W-1:0] status_q;
  logic [`IRQFE_STAT_W-1:0] mask_q;
  irqfe_bus_t  busState_q;
  logic        access;
  logic        reqFirst;
  logic [15:0] wrLow;
  logic [15:0] wrMask;
  logic [15:0] fwdNow;
  logic        serrFwdNow;

  function automatic logic hit(input logic [`IRQFE_ADDR_W-1:0] a,
                               input logic [`IRQFE_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic mapped(input logic [`IRQFE_ADDR_W-1:0] a);
    mapped = hit(a, `IRQFE_OFF_FLAGS4) | hit(a, `IRQFE_OFF_ENABLES0)
             | hit(a, `IRQFE_OFF_STATUS) | hit(a, `IRQFE_OFF_MASK);
  endfunction

  // first cycle waits and latches read data, second cycle commits writes
  assign reqFirst = (avRead | avWrite) && (busState_q == IRQFE_IDLE);
  assign access = (avRead | avWrite) && (busState_q == IRQFE_DONE);
  assign avWaitRequest = reqFirst;
  assign wrLow = avWriteData[15:0];
  assign wrMask = {{8{avByteEnable[1]}}, {8{avByteEnable[0]}}};

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      busState_q <= IRQFE_IDLE;
    end else begin
      case (busState_q)
        IRQFE_IDLE: if (avRead | avWrite) busState_q <= IRQFE_DONE;
        IRQFE_DONE: busState_q <= IRQFE_IDLE;
        default:    busState_q <= IRQFE_IDLE;
      endcase
    end
  end

  // flags group 4: set wins over software write
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      flags4_q <= `IRQFE_REG_RESET; // R6
    end else begin
      if (access && avWrite && hit(avAddress, `IRQFE_OFF_FLAGS4)) begin
        flags4_q <= ((flags4_q & ~wrMask) | (wrLow & wrMask)) & `IRQFE_FLAG4_MASK; // R4 R5 R6
      end
      if (serialErrorEvent) begin
        flags4_q[`IRQFE_SERR_BIT] <= 1'b1; // R1 R2 R9
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      enables0_q <= `IRQFE_REG_RESET; // R7
    end else if (access && avWrite && hit(avAddress, `IRQFE_OFF_ENABLES0)) begin
      enables0_q <= ((enables0_q & ~wrMask) | (wrLow & wrMask)) & `IRQFE_EN0_MASK; // R7
    end
  end

  // forwarding, one per enable position
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : gFwd
      assign fwdNow[g] = srcFlags[g] & enables0_q[g]; // R8 R9
    end
  endgenerate
  assign serrFwdNow = flags4_q[`IRQFE_SERR_BIT] & serialErrorEnable; // R9

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irqForward         <= 16'h0000;
      serialErrorForward <= 1'b0;
      irqEnables         <= 16'h0000;
      serialErrorFlag    <= 1'b0;
    end else begin
      irqForward         <= fwdNow; // R9
      serialErrorForward <= serrFwdNow; // R9
      irqEnables         <= enables0_q;
      serialErrorFlag    <= flags4_q[`IRQFE_SERR_BIT]; // R3
    end
  end

  // local sticky status, write one to clear, set wins
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      status_q <= `IRQFE_STAT_RESET;
      mask_q   <= `IRQFE_STAT_RESET;
    end else begin
      if (access && avWrite && hit(avAddress, `IRQFE_OFF_MASK) && avByteEnable[0]) begin
        mask_q <= avWriteData[`IRQFE_STAT_W-1:0];
      end
      if (access && avWrite && hit(avAddress, `IRQFE_OFF_STATUS) && avByteEnable[0]) begin
        status_q <= (status_q & ~avWriteData[`IRQFE_STAT_W-1:0])
                    | {(|fwdNow | serrFwdNow), serialErrorEvent};
      end else begin
        status_q <= status_q | {(|fwdNow | serrFwdNow), serialErrorEvent};
      end
    end
  end

  assign irqOut = |(status_q & mask_q);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      avReadData <= 32'h00000000;
    end else if (reqFirst && avRead) begin
      if (hit(avAddress, `IRQFE_OFF_FLAGS4)) begin
        avReadData <= {16'h0000, flags4_q & `IRQFE_FLAG4_MASK}; // R2 R3 R4 R5
      end else if (hit(avAddress, `IRQFE_OFF_ENABLES0)) begin
        avReadData <= {16'h0000, enables0_q & `IRQFE_EN0_MASK}; // R7
      end else if (hit(avAddress, `IRQFE_OFF_STATUS)) begin
        avReadData <= {30'h00000000, status_q};
      end else if (hit(avAddress, `IRQFE_OFF_MASK)) begin
        avReadData <= {30'h00000000, mask_q};
      end else begin
        avReadData <= 32'h00000000;
      end
    end
  end

  a_serr_sets: assert property (@(posedge sys_clk) disable iff (!rst_b)
    serialErrorEvent |=> flags4_q[`IRQFE_SERR_BIT]) // R2
    else $error("serial error flag did not set");
  a_flag4_unused: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (flags4_q & ~`IRQFE_FLAG4_MASK) == 16'h0000) // R4
    else $error("unused flag bits set");
  a_flag4_bit0: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !flags4_q[0]) // R5
    else $error("flag bit 0 set");
  a_en0_unused: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !enables0_q[15] && !enables0_q[14] && !enables0_q[4]) // R7
    else $error("unused enable bits set");
  a_fwd_gated: assert property (@(posedge sys_clk) disable iff (!rst_b)
    irqForward == ($past(srcFlags) & $past(enables0_q))) // R8
    else $error("forward not gated by enable");
  a_serr_fwd: assert property (@(posedge sys_clk) disable iff (!rst_b)
    serialErrorForward |-> $past(flags4_q[`IRQFE_SERR_BIT]) && $past(serialErrorEnable)) // R9
    else $error("serial error forwarded without flag and enable");
  a_serr_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !$past(serialErrorEvent) && !$past(flags4_q[`IRQFE_SERR_BIT])
    && !$past(access && avWrite) |-> !flags4_q[`IRQFE_SERR_BIT]) // R3
    else $error("serial error flag set without cause");
  a_read_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
    reqFirst && avRead && hit(avAddress, `IRQFE_OFF_FLAGS4)
    |=> avReadData == {16'h0000, $past(flags4_q)}) // R1
    else $error("flag read wrong");
  a_serr_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    access && avWrite && hit(avAddress, `IRQFE_OFF_FLAGS4) && avByteEnable[0]
    && !serialErrorEvent |=> flags4_q[1] == $past(avWriteData[1])) // R6
    else $error("serial error flag not writable");

  a_wait_first: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (avRead || avWrite) && (busState_q == IRQFE_IDLE)
    |-> avWaitRequest)
    else $error("first request cycle did not wait");

  a_wait_done: assert property (@(posedge sys_clk) disable iff (!rst_b)
    busState_q == IRQFE_DONE
    |-> !avWaitRequest)
    else $error("second request cycle still waiting");

  a_wait_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !avRead && !avWrite
    |-> !avWaitRequest)
    else $error("waitrequest without request");

  a_bus_done: assert property (@(posedge sys_clk) disable iff (!rst_b)
    reqFirst
    |=> busState_q == IRQFE_DONE)
    else $error("bus did not advance");

  a_bus_back: assert property (@(posedge sys_clk) disable iff (!rst_b)
    busState_q == IRQFE_DONE
    |=> busState_q == IRQFE_IDLE)
    else $error("bus did not return to idle");

  a_read_en0: assert property (@(posedge sys_clk) disable iff (!rst_b) // R7
    reqFirst && avRead && hit(avAddress, `IRQFE_OFF_ENABLES0)
    |=> avReadData == {16'h0000, $past(enables0_q)})
    else $error("enable read wrong");

  a_read_stat: assert property (@(posedge sys_clk) disable iff (!rst_b)
    reqFirst && avRead && hit(avAddress, `IRQFE_OFF_STATUS)
    |=> avReadData == {30'h00000000, $past(status_q)})
    else $error("status read wrong");

  a_read_mask: assert property (@(posedge sys_clk) disable iff (!rst_b)
    reqFirst && avRead && hit(avAddress, `IRQFE_OFF_MASK)
    |=> avReadData == {30'h00000000, $past(mask_q)})
    else $error("mask read wrong");

  a_read_unmap: assert property (@(posedge sys_clk) disable iff (!rst_b)
    reqFirst && avRead && !mapped(avAddress)
    |=> avReadData == 32'h00000000)
    else $error("unmapped read not zero");

  a_read_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(reqFirst && avRead)
    |=> $stable(avReadData))
    else $error("read data moved without read");

  a_read_upper: assert property (@(posedge sys_clk) disable iff (!rst_b) // R4 R7
    avReadData[31:16]
    == 16'h0000)
    else $error("upper read half not zero");

  a_en0_write: assert property (@(posedge sys_clk) disable iff (!rst_b) // R7
    access && avWrite && hit(avAddress, `IRQFE_OFF_ENABLES0) && (avByteEnable[1:0] == 2'h3)
    |=> enables0_q == ($past(avWriteData[15:0]) & `IRQFE_EN0_MASK))
    else $error("enable write lost");

  a_en0_keep: assert property (@(posedge sys_clk) disable iff (!rst_b) // R7
    !(access && avWrite && hit(avAddress, `IRQFE_OFF_ENABLES0))
    |=> $stable(enables0_q))
    else $error("enables changed without write");

  a_en0_byte_hi: assert property (@(posedge sys_clk) disable iff (!rst_b) // R7
    access && avWrite && hit(avAddress, `IRQFE_OFF_ENABLES0) && !avByteEnable[1]
    |=> enables0_q[15:8] == $past(enables0_q[15:8]))
    else $error("disabled byte lane written");

  a_flag4_keep: assert property (@(posedge sys_clk) disable iff (!rst_b) // R2
    !(access && avWrite && hit(avAddress, `IRQFE_OFF_FLAGS4)) && !serialErrorEvent
    |=> $stable(flags4_q))
    else $error("flags changed without cause");

  a_serr_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b) // R2
    flags4_q[`IRQFE_SERR_BIT] && !(access && avWrite && hit(avAddress, `IRQFE_OFF_FLAGS4))
    |=> flags4_q[`IRQFE_SERR_BIT])
    else $error("serial error flag lost");

  a_flag4_write0: assert property (@(posedge sys_clk) disable iff (!rst_b) // R6
    access && avWrite && hit(avAddress, `IRQFE_OFF_FLAGS4) && avByteEnable[0]
    && !serialErrorEvent && !avWriteData[`IRQFE_SERR_BIT] |=> !flags4_q[`IRQFE_SERR_BIT])
    else $error("serial error flag not cleared");

  a_stat_event: assert property (@(posedge sys_clk) disable iff (!rst_b)
    serialErrorEvent
    |=> status_q[`IRQFE_STAT_SERR])
    else $error("status event bit not set");

  a_stat_fwd: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (|fwdNow) || serrFwdNow
    |=> status_q[`IRQFE_STAT_FWD])
    else $error("status forward bit not set");

  a_stat_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
    access && avWrite && hit(avAddress, `IRQFE_OFF_STATUS) && avByteEnable[0]
    && avWriteData[`IRQFE_STAT_SERR] && !serialErrorEvent |=> !status_q[`IRQFE_STAT_SERR])
    else $error("status event bit not cleared");

  a_stat_keep: assert property (@(posedge sys_clk) disable iff (!rst_b)
    status_q[`IRQFE_STAT_SERR] && !(access && avWrite && hit(avAddress, `IRQFE_OFF_STATUS))
    |=> status_q[`IRQFE_STAT_SERR])
    else $error("status event bit lost");

  a_stat_fwd_clr: assert property (@(posedge sys_clk) disable iff (!rst_b)
    access && avWrite && hit(avAddress, `IRQFE_OFF_STATUS) && avByteEnable[0]
    && avWriteData[`IRQFE_STAT_FWD] && !((|fwdNow) || serrFwdNow) |=> !status_q[`IRQFE_STAT_FWD])
    else $error("status forward bit not cleared");

  a_mask_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    access && avWrite && hit(avAddress, `IRQFE_OFF_MASK) && avByteEnable[0]
    |=> mask_q == $past(avWriteData[`IRQFE_STAT_W-1:0]))
    else $error("mask write lost");

  a_mask_keep: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(access && avWrite && hit(avAddress, `IRQFE_OFF_MASK))
    |=> $stable(mask_q))
    else $error("mask changed without write");

  a_copy_en: assert property (@(posedge sys_clk) disable iff (!rst_b) // R7
    irqEnables
    == $past(enables0_q))
    else $error("enable copy wrong");

  a_copy_flag: assert property (@(posedge sys_clk) disable iff (!rst_b) // R2 R3
    serialErrorFlag
    == $past(flags4_q[`IRQFE_SERR_BIT]))
    else $error("flag copy wrong");

  a_serr_fwd_on: assert property (@(posedge sys_clk) disable iff (!rst_b) // R8 R9
    $past(flags4_q[`IRQFE_SERR_BIT]) && $past(serialErrorEnable)
    |-> serialErrorForward)
    else $error("enabled serial error not forwarded");

  a_serr_blocked: assert property (@(posedge sys_clk) disable iff (!rst_b) // R8
    !$past(serialErrorEnable)
    |-> !serialErrorForward)
    else $error("disabled serial error forwarded");

  a_fwd_zero_en: assert property (@(posedge sys_clk) disable iff (!rst_b) // R8
    enables0_q == `IRQFE_REG_RESET
    |=> irqForward == 16'h0000)
    else $error("forward with all enables off");

  a_fwd_unused: assert property (@(posedge sys_clk) disable iff (!rst_b) // R7 R8
    (irqForward & ~`IRQFE_EN0_MASK)
    == 16'h0000)
    else $error("forward on unused position");

  a_reset_clean: assert property (@(posedge sys_clk) // R6 R7
    !rst_b
    |=> flags4_q == `IRQFE_REG_RESET && enables0_q == `IRQFE_REG_RESET)
    else $error("registers not cleared by reset");

  a_reset_bus: assert property (@(posedge sys_clk)
    !rst_b
    |=> busState_q == IRQFE_IDLE && avReadData == 32'h00000000)
    else $error("bus not cleared by reset");
endmodule
`default_nettype wire

// ### rtl/irqfe_cfg.svh
`ifndef IRQFE_CFG_SVH
`define IRQFE_CFG_SVH
`define IRQFE_ADDR_W        4
`define IRQFE_OFF_FLAGS4    4'h0
`define IRQFE_OFF_ENABLES0  4'h4
`define IRQFE_OFF_STATUS    4'h8
`define IRQFE_OFF_MASK      4'hc
`define IRQFE_FLAG4_MASK    16'h0002
`define IRQFE_EN0_MASK      16'h3fef
`define IRQFE_REG_RESET     16'h0000
`define IRQFE_SERR_BIT      1
`define IRQFE_NSRC          13
`define IRQFE_STAT_W        2
`define IRQFE_STAT_SERR     0
`define IRQFE_STAT_FWD      1
`define IRQFE_STAT_RESET    2'h0
`endif

// ### rtl/irqfe_pkg.sv
`default_nettype none
package irqfe_pkg;
  typedef logic [15:0] irqfe_word_t;
  typedef enum logic {IRQFE_IDLE, IRQFE_DONE} irqfe_bus_t;
endpackage
`default_nettype wire

// ### sim/irqfe_flag_enable_tb.sv
`include "irqfe_cfg.svh"
`default_nettype none
module irqfe_flag_enable_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst_b, avRead, avWrite, serialErrorEvent, serialErrorEnable;
  logic [3:0]  avAddress, avByteEnable;
  logic [31:0] avWriteData, avReadData, q;
  logic        avWaitRequest, serialErrorFlag, serialErrorForward, irqOut;
  logic [15:0] srcFlags, irqEnables, irqForward;
  int          errors, checked;
  irqfe_flag_enable irqfe_flag_enable_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite), .avWriteData(avWriteData),
    .avByteEnable(avByteEnable), .avReadData(avReadData), .avWaitRequest(avWaitRequest),
    .serialErrorEvent(serialErrorEvent), .srcFlags(srcFlags), .irqEnables(irqEnables),
    .serialErrorFlag(serialErrorFlag), .irqForward(irqForward),
    .serialErrorForward(serialErrorForward), .serialErrorEnable(serialErrorEnable),
    .irqOut(irqOut));
  always #2 sys_clk = ~sys_clk;
  task automatic test_done();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    logic w;
    n = 0;
    @(posedge sys_clk);
    avAddress <= a;
    avWriteData <= d;
    avWrite <= wr;
    avRead <= !wr;
    do begin
      @(negedge sys_clk);
      w = avWaitRequest;
      q = avReadData;
      n++;
      @(posedge sys_clk);
    end while (w !== 1'b0 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("Error at %0t: bus hang", $time);
    end
    avRead <= 1'b0;
    avWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic t_regs();
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    bus(1'b1, 4'h4, 32'hffffffff);
    rd(4'h4, 32'h3fef);
    repeat (2) @(posedge sys_clk);
    chk(irqEnables, 32'h3fef);
    bus(1'b1, 4'h4, 32'h0);
    bus(1'b1, 4'h0, 32'hffffffff);
    rd(4'h0, 32'h0002);
    chk(serialErrorFlag, 32'h1);
    bus(1'b1, 4'h0, 32'h0);
    rd(4'h0, 32'h0);
    bus(1'b1, 4'h2, 32'hffffffff);
    rd(4'h2, 32'h0);
    rd(4'h4, 32'h0);
  endtask
  task automatic t_event();
    @(posedge sys_clk);
    serialErrorEvent <= 1'b1;
    @(posedge sys_clk);
    serialErrorEvent <= 1'b0;
    rd(4'h0, 32'h0002);
    chk(serialErrorForward, 32'h0);
    serialErrorEnable <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(serialErrorForward, 32'h1);
  endtask
  task automatic t_fwd();
    srcFlags <= 16'hffff;
    bus(1'b1, 4'h4, 32'h0021);
    repeat (2) @(posedge sys_clk);
    chk(irqForward, 32'h0021);
    bus(1'b1, 4'h4, 32'h0);
    srcFlags <= 16'h0;
    repeat (2) @(posedge sys_clk);
    chk(irqForward, 32'h0);
  endtask
  task automatic t_irq();
    rd(4'h8, 32'h3);
    bus(1'b1, 4'hc, 32'h1);
    @(negedge sys_clk);
    chk(irqOut, 32'h1);
    bus(1'b1, 4'hc, 32'h0);
    @(negedge sys_clk);
    chk(irqOut, 32'h0);
    bus(1'b1, 4'hc, 32'h1);
    serialErrorEnable <= 1'b0;
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b1, 4'h8, 32'h3);
    rd(4'h8, 32'h0);
    @(negedge sys_clk);
    chk(irqOut, 32'h0);
  endtask
  initial begin
    {sys_clk, rst_b, avRead, avWrite, serialErrorEvent, serialErrorEnable} = '0;
    {avAddress, avWriteData, srcFlags, errors, checked} = '0;
    avByteEnable = 4'hf;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs();
    t_event();
    t_fwd();
    t_irq();
    test_done();
  end
  initial begin
    #40000;
    errors++;
    test_done();
  end
endmodule
`default_nettype wire
